// File: core/pdm_defs.svh
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// Register byte addresses on the plain register port
`define PDM_ADDR_W 16
`define PDM_ADDR_SYSCTL 16'hFFF2
`define PDM_ADDR_MODHALT 16'hFF5E
`define PDM_ADDR_PWRSTAT 16'hFF60

// Reset values
`define PDM_SYSCTL_RST 8'h0B
`define PDM_MODHALT_RST 8'h40

// System control fields
`define PDM_SYS_HW_STANDBY_PIN_SEL 7
`define PDM_SYS_WAIT_HI 6
`define PDM_SYS_WAIT_LO 4
`define PDM_SYS_RAM_EN 0

// Module halt fields
`define PDM_MH_CLKOUT_STOP 7
`define PDM_MH_RSVD 6
`define PDM_MH_TIMER 5
`define PDM_MH_SER0 4
`define PDM_MH_SER1 3
`define PDM_MH_ADC 0
// Writable bits: 7,5,4,3,0; bit 6 fixed at 1, bits 2..1 hold
`define PDM_MH_WMASK 8'hB9

// Settle wait counts in clock states
`define PDM_WAIT_0 18'h02000
`define PDM_WAIT_1 18'h04000
`define PDM_WAIT_2 18'h08000
`define PDM_WAIT_3 18'h10000
`define PDM_WAIT_4 18'h20000
`define PDM_WAIT_5 18'h00400
`define PDM_WAIT_W 18

// Minimum crystal settling time in ns and its cycle count at 100 MHz
`define PDM_CLK_NS 10
`define PDM_XTAL_MIN_NS 7000000
`define PDM_XTAL_MIN_CYC ((`PDM_XTAL_MIN_NS + `PDM_CLK_NS - 1) / `PDM_CLK_NS)

`endif

// File: core/pdm_pkg.sv
package pdm_pkg;

	typedef enum logic [1:0] {
		PDM_RUN = 2'h0,
		PDM_SLEEP = 2'h1,
		PDM_SWSTBY = 2'h3,
		PDM_SETTLE = 2'h2
	} pdm_state_t;

	typedef struct packed {
		pdm_state_t state;
		logic [7:0] sysctl;
		logic [7:0] modhalt;
		logic [17:0] wait_cnt;
		logic [7:0] rdata;
		logic [3:0] mod_init;
		logic illegal_wait;
	} pdm_regs_t;

endpackage

// File: core/pdm_power_ctrl.sv
`timescale 1ns/1ps
`include "pdm_defs.svh"
module pdm_power_ctrl (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic i_hw_standby_pin_n,
	input wire logic [`PDM_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_sleep_insn,
	input wire logic i_wake_irq,
	output logic [7:0] o_rdata,
	output logic o_cpu_halt,
	output logic o_osc_run,
	output logic o_clk_gate,
	output logic o_irq_resume,
	output logic o_sysclk_out_en,
	output logic o_timer_unit_halt,
	output logic o_serial_zero_halt,
	output logic o_serial_one_halt,
	output logic o_adc_halt,
	output logic o_timer_unit_init,
	output logic o_serial_zero_init,
	output logic o_serial_one_init,
	output logic o_adc_init,
	output logic o_swstby_mod_reset,
	output logic o_onchip_ram_enable,
	output logic o_illegal_wait
);

	pdm_pkg::pdm_regs_t cur_ff;
	pdm_pkg::pdm_regs_t nxt_ff;
	logic irq_resume_ff;
	logic nxt_irq_resume;

	////////////////////////////////////////////////////////////////////////
	// Settle wait decode

	function automatic logic [`PDM_WAIT_W-1:0] wait_states(
		input logic [2:0] code
	);
		case (code)
		3'h0: wait_states = `PDM_WAIT_0;
		3'h1: wait_states = `PDM_WAIT_1;
		3'h2: wait_states = `PDM_WAIT_2;
		3'h3: wait_states = `PDM_WAIT_3;
		3'h4: wait_states = `PDM_WAIT_4;
		3'h5: wait_states = `PDM_WAIT_5;
		// Illegal codes fall back to the longest wait, the safe side
		default: wait_states = `PDM_WAIT_4;
		endcase
	endfunction

	function automatic logic is_reg(
		input logic [`PDM_ADDR_W-1:0] a,
		input logic [`PDM_ADDR_W-1:0] r
	);
		is_reg = (a == r);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	logic [2:0] wait_code;
	logic [7:0] mh_new;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_irq_resume = 1'b0;
		nxt_ff.mod_init = 4'h0;
		wait_code = cur_ff.sysctl[`PDM_SYS_WAIT_HI:`PDM_SYS_WAIT_LO];
		mh_new = cur_ff.modhalt;

		// Register writes
		if (i_wr && is_reg(i_addr, `PDM_ADDR_SYSCTL)) begin
			// Standby select leaves 1 through a written 0, a reset or the standby pin
			nxt_ff.sysctl = i_wdata;
		end
		if (i_wr && is_reg(i_addr, `PDM_ADDR_MODHALT)) begin
			mh_new = (i_wdata & `PDM_MH_WMASK)
				| (cur_ff.modhalt & ~`PDM_MH_WMASK);
			mh_new[`PDM_MH_RSVD] = 1'b1;
			nxt_ff.modhalt = mh_new;
			// One-cycle init pulse on a 0 to 1 standby transition
			nxt_ff.mod_init = {
				mh_new[`PDM_MH_TIMER] & ~cur_ff.modhalt[`PDM_MH_TIMER],
				mh_new[`PDM_MH_SER0] & ~cur_ff.modhalt[`PDM_MH_SER0],
				mh_new[`PDM_MH_SER1] & ~cur_ff.modhalt[`PDM_MH_SER1],
				mh_new[`PDM_MH_ADC] & ~cur_ff.modhalt[`PDM_MH_ADC]
			};
		end
		nxt_ff.illegal_wait =
			(nxt_ff.sysctl[`PDM_SYS_WAIT_HI:`PDM_SYS_WAIT_LO + 1] == 2'h3);

		// Read data, valid in the cycle after the strobe
		nxt_ff.rdata = 8'h00;
		if (i_rd) begin
			if (is_reg(i_addr, `PDM_ADDR_SYSCTL)) begin
				nxt_ff.rdata = cur_ff.sysctl;
			end else if (is_reg(i_addr, `PDM_ADDR_MODHALT)) begin
				nxt_ff.rdata = cur_ff.modhalt | 8'h40;
			end else if (is_reg(i_addr, `PDM_ADDR_PWRSTAT)) begin
				nxt_ff.rdata = {5'h00, cur_ff.illegal_wait, cur_ff.state};
			end else begin
				nxt_ff.rdata = 8'h00;
			end
		end

		// Power state sequencing
		case (cur_ff.state)
		pdm_pkg::PDM_RUN: begin
			if (i_sleep_insn) begin
				if (cur_ff.sysctl[`PDM_SYS_HW_STANDBY_PIN_SEL]) begin
					nxt_ff.state = pdm_pkg::PDM_SWSTBY;
				end else begin
					nxt_ff.state = pdm_pkg::PDM_SLEEP;
				end
			end
		end
		pdm_pkg::PDM_SLEEP: begin
			if (i_wake_irq) begin
				nxt_ff.state = pdm_pkg::PDM_RUN;
				nxt_irq_resume = 1'b1;
			end
		end
		pdm_pkg::PDM_SWSTBY: begin
			if (i_wake_irq) begin
				// Oscillator restarts; count from here
				nxt_ff.state = pdm_pkg::PDM_SETTLE;
				nxt_ff.wait_cnt = wait_states(wait_code) - 18'h00001;
			end
		end
		pdm_pkg::PDM_SETTLE: begin
			if (cur_ff.wait_cnt == '0) begin
				nxt_ff.state = pdm_pkg::PDM_RUN;
				nxt_irq_resume = 1'b1;
			end else begin
				nxt_ff.wait_cnt = cur_ff.wait_cnt - 18'h00001;
			end
		end
		default: nxt_ff.state = pdm_pkg::PDM_RUN;
		endcase

		// Hardware standby pin acts like reset on the control registers
		if (!i_hw_standby_pin_n) begin
			nxt_ff.modhalt = `PDM_MODHALT_RST;
			nxt_ff.sysctl = `PDM_SYSCTL_RST;
			nxt_ff.state = pdm_pkg::PDM_RUN;
			nxt_ff.wait_cnt = '0;
			nxt_ff.mod_init = 4'h0;
			nxt_irq_resume = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cur_ff.state <= pdm_pkg::PDM_RUN;
			cur_ff.sysctl <= `PDM_SYSCTL_RST;
			cur_ff.modhalt <= `PDM_MODHALT_RST;
			cur_ff.wait_cnt <= '0;
			cur_ff.rdata <= 8'h00;
			cur_ff.mod_init <= 4'h0;
			cur_ff.illegal_wait <= 1'b0;
			irq_resume_ff <= 1'b0;
		end else begin
			cur_ff <= nxt_ff;
			irq_resume_ff <= nxt_irq_resume;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	logic in_hw_standby_pin;

	assign in_hw_standby_pin = (cur_ff.state == pdm_pkg::PDM_SWSTBY)
		|| (cur_ff.state == pdm_pkg::PDM_SETTLE);
	assign o_rdata = cur_ff.rdata;
	assign o_cpu_halt = (cur_ff.state != pdm_pkg::PDM_RUN);
	assign o_osc_run = (cur_ff.state != pdm_pkg::PDM_SWSTBY);
	// Chip clocks held until the settle count expires
	assign o_clk_gate = !in_hw_standby_pin;
	assign o_irq_resume = irq_resume_ff;
	// Module halt bits survive software standby; modules reset there anyway
	assign o_swstby_mod_reset = in_hw_standby_pin;
	assign o_sysclk_out_en = !cur_ff.modhalt[`PDM_MH_CLKOUT_STOP];
	assign o_timer_unit_halt = cur_ff.modhalt[`PDM_MH_TIMER];
	assign o_serial_zero_halt = cur_ff.modhalt[`PDM_MH_SER0];
	assign o_serial_one_halt = cur_ff.modhalt[`PDM_MH_SER1];
	assign o_adc_halt = cur_ff.modhalt[`PDM_MH_ADC];
	assign o_timer_unit_init = cur_ff.mod_init[3];
	assign o_serial_zero_init = cur_ff.mod_init[2];
	assign o_serial_one_init = cur_ff.mod_init[1];
	assign o_adc_init = cur_ff.mod_init[0];
	assign o_onchip_ram_enable = cur_ff.sysctl[`PDM_SYS_RAM_EN];
	assign o_illegal_wait = cur_ff.illegal_wait;

endmodule

// File: tb/pdm_power_ctrl_asserts.sv
`timescale 1ns/1ps
module pdm_chk (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic i_hw_standby_pin_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_sleep_insn,
	input wire logic [7:0] o_rdata,
	input wire logic o_cpu_halt,
	input wire logic o_osc_run,
	input wire logic o_clk_gate,
	input wire logic o_irq_resume,
	input wire logic o_sysclk_out_en,
	input wire logic o_timer_unit_halt,
	input wire logic o_adc_halt,
	input wire logic o_timer_unit_init,
	input wire logic o_swstby_mod_reset,
	input wire logic o_illegal_wait
);
default clocking @(posedge I_MCLK); endclocking
default disable iff (!I_RST_N);
wire mw = i_wr && i_addr == 16'hFF5E && i_hw_standby_pin_n;
wire sw = i_wr && i_addr == 16'hFFF2 && i_hw_standby_pin_n;
property p_clk; mw |=> o_sysclk_out_en == !$past(i_wdata[7]); endproperty
a_clk: assert property (p_clk) else $error("clock out gate");
property p_hlt;
	mw |=> o_timer_unit_halt == $past(i_wdata[5]) &&
		o_adc_halt == $past(i_wdata[0]);
endproperty
a_hlt: assert property (p_hlt) else $error("halt bits");
property p_hw;
	!i_hw_standby_pin_n |=> o_sysclk_out_en && !o_timer_unit_halt;
endproperty
a_hw: assert property (p_hw) else $error("standby pin init");
property p_rsv; i_rd && i_addr == 16'hFF5E |=> o_rdata[6]; endproperty
a_rsv: assert property (p_rsv) else $error("fixed bit");
property p_ini;
	mw && i_wdata[5] && !o_timer_unit_halt |-> ##[1:2] o_timer_unit_init;
endproperty
a_ini: assert property (p_ini) else $error("init pulse");
property p_osc;
	$fell(o_osc_run) |-> o_cpu_halt && !o_clk_gate;
endproperty
a_osc: assert property (p_osc) else $error("osc stop");
property p_slp; i_sleep_insn && !o_cpu_halt |=> o_cpu_halt; endproperty
a_slp: assert property (p_slp) else $error("cpu halt");
property p_rsm;
	$rose(o_clk_gate) && $past(i_hw_standby_pin_n) |-> ##[0:1] o_irq_resume;
endproperty
a_rsm: assert property (p_rsm) else $error("resume pulse");
property p_mrs; o_swstby_mod_reset == !o_clk_gate; endproperty
a_mrs: assert property (p_mrs) else $error("module reset");
property p_ill;
	sw |=> o_illegal_wait == ($past(i_wdata[6:5]) == 2'h3);
endproperty
a_ill: assert property (p_ill) else $error("illegal code");
endmodule
////////////////////////////////////////
bind pdm_power_ctrl pdm_chk pdm_chk_u (.*);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
logic clk = 0, rn = 0, hs = 1, w = 0, r = 0, sl = 0, wk = 0;
logic [15:0] a = 16'h0000;
logic [7:0] d = 8'h00, d0;
logic [15:0] ua;
logic [31:0] s = 32'hbaa7;
int mismatches = 0, comparisons = 0, n;
wire [7:0] q;
wire halt, osc, gate, cko, tmr, adc, ill, s0h, s1h, ram, irq;
pdm_power_ctrl dut_u (.I_MCLK(clk), .I_RST_N(rn), .i_hw_standby_pin_n(hs),
	.i_addr(a), .i_wdata(d), .i_wr(w), .i_rd(r), .i_sleep_insn(sl),
	.i_wake_irq(wk), .o_rdata(q), .o_cpu_halt(halt), .o_osc_run(osc),
	.o_clk_gate(gate), .o_irq_resume(irq), .o_sysclk_out_en(cko),
	.o_timer_unit_halt(tmr), .o_serial_zero_halt(s0h),
	.o_serial_one_halt(s1h),
	.o_adc_halt(adc), .o_timer_unit_init(), .o_serial_zero_init(),
	.o_serial_one_init(), .o_adc_init(), .o_swstby_mod_reset(),
	.o_onchip_ram_enable(ram), .o_illegal_wait(ill));
always #5 clk = ~clk;
////////////////////////////////////////
function automatic logic [7:0] xs();
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s[7:0];
endfunction
// Bit 6 forced, bits 2..1 never stored
function automatic logic [7:0] mh(input logic [7:0] v);
	return (v & 8'hB9) | 8'h40;
endfunction
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
	comparisons++;
	if (g !== e) begin
		mismatches++;
		$display("wrong value %s exp %h got %h", nm, e, g);
	end
endtask
task automatic wr(input logic [15:0] ad, input logic [7:0] v);
	@(posedge clk) begin a <= ad; d <= v; w <= 1; end
	@(posedge clk) w <= 0;
endtask
task automatic rdc(input logic [15:0] ad, input logic [7:0] e, input string nm);
	@(posedge clk) begin a <= ad; r <= 1; end
	@(posedge clk) r <= 0;
	@(negedge clk) chk(nm, e, q);
endtask
task automatic end_of_test();
	$display("mismatches %0d comparisons %0d", mismatches, comparisons);
	if (mismatches == 0 && comparisons > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
////////////////////////////////////////
initial begin
	repeat (20) @(posedge clk);
	rn <= 1;
	rdc(16'hFFF2, 8'h0B, "sysctl");
	rdc(16'hFF5E, 8'h40, "modhalt");
	chk("ram", 8'h01, {7'h0, ram});
	// Random rewrites: halt bits read back and checked at the outputs, then an unmapped write reads 0
	for (int i = 0; i < 30; i++) begin
		d0 = xs();
		wr(16'hFF5E, d0);
		rdc(16'hFF5E, mh(d0), "modhalt");
		chk("halts", {3'h0, !d0[7], d0[5], d0[4], d0[3], d0[0]},
			{3'h0, cko, tmr, s0h, s1h, adc});
		ua = {8'hFE, xs()};
		wr(ua, 8'hFF);
		rdc(ua, 8'h00, "unmapped");
	end
	// Codes 11x flagged, others legal
	for (int c = 0; c < 8; c++) begin
		wr(16'hFFF2, {1'b0, c[2:0], 4'hB});
		rdc(16'hFF60, {5'h0, c[2:1] == 2'h3, 2'h0}, "status");
	end
	wr(16'hFF5E, 8'h20);
	// External clock assumed: the short 1024-state code is allowed
	wr(16'hFFF2, 8'hD0);
	@(posedge clk) sl <= 1;
	@(posedge clk) sl <= 0;
	@(negedge clk) chk("osc", 8'h00, {7'h0, osc});
	@(posedge clk) wk <= 1;
	n = 0;
	do begin
		@(posedge clk) wk <= 0;
		@(negedge clk) n++;
	end while (!gate && n < 2000);
	if (!gate) begin
		mismatches++;
		end_of_test();
	end
	chk("settle", 8'h01, {7'h0, n == 1025});
	rdc(16'hFFF2, 8'hD0, "sysctl");
	rdc(16'hFF5E, 8'h60, "modhalt");
	// Standby select cleared here, so the sleep below keeps the oscillator running
	wr(16'hFFF2, 8'h50);
	@(posedge clk) sl <= 1;
	@(posedge clk) sl <= 0;
	@(negedge clk) chk("sleep", 8'h03, {6'h0, osc, halt});
	@(posedge clk) wk <= 1;
	@(posedge clk) wk <= 0;
	@(negedge clk) chk("wake", 8'h01, {6'h0, halt, irq});
	@(posedge clk) hs <= 0;
	@(posedge clk) hs <= 1;
	rdc(16'hFF5E, 8'h40, "modhalt");
	end_of_test();
end
endmodule
